// ==== bench/iopo_pins_model.sv ====
// pad model: resolves each pin level from the block and the outside
`timescale 1ns/1ps
`default_nettype none

module iopo_pins_model
   import iopo_pkg::*;
(
   // pad controls
   input  wire iopo_bank_t pin_out_i,
   input  wire iopo_bank_t pin_oe_i,
   input  wire iopo_bank_t pin_pu_i,
   // outside level, seen on undriven pins without pull-up
   input  wire iopo_bank_t ext_lvl_i,
   // resolved level
   output var iopo_bank_t  pin_lvl_o
);
   // driven value wins, then pull-up, then outside level
   assign pin_lvl_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & pin_pu_i)
                    | (~pin_oe_i & ~pin_pu_i & ext_lvl_i);
endmodule
`default_nettype wire

// ==== bench/iopo_top_tb.sv ====
// self-checking bench of the pin override block
`timescale 1ns/1ps
`default_nettype none

module iopo_top_tb
   import iopo_pkg::*;
;
   logic             clk_i   = 1'b0;
   logic             rst_n_i = 1'b0;
   logic [7:0]       addr    = 8'h00;
   logic [7:0]       wdata   = 8'h00;
   logic             wr      = 1'b0;
   logic             rd      = 1'b0;
   logic             ce      = 1'b1;
   logic [7:0]       rdata;
   iopo_bank_t       lvl, pout, poe, ppu;
   iopo_bank_t       ext     = '0;
   iopo_periph_in_s  pi      = '0;
   iopo_periph_out_s po;
   logic             xmem, osc;
   int               error_cnt       = 0;
   int               samples_checked = 0;

   // 250 MHz clock
   always #2 clk_i = ~clk_i;

   // block and pads
   iopo_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .pin_lvl_i(lvl), .pin_out_o(pout),
      .pin_oe_o(poe), .pin_pu_o(ppu), .periph_i(pi), .periph_o(po),
      .ext_memory_on_o(xmem), .osc_pins_on_o(osc));
   iopo_pins_model pads (.pin_out_i(pout), .pin_oe_i(poe), .pin_pu_i(ppu),
      .ext_lvl_i(ext), .pin_lvl_o(lvl));

   // compare and count
   task automatic chk(input string nm, input logic [39:0] s, e);
      samples_checked++;
      if (s !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", nm, e, s);
      end
   endtask
   // one-cycle write strobe
   task automatic wr8(input logic [7:0] a, d);
      @(posedge clk_i);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk_i);
      wr    <= 1'b0;
   endtask
   // one-cycle read strobe, data checked the cycle after
   task automatic rdc(input logic [7:0] a, e);
      @(posedge clk_i);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk_i);
      rd   <= 1'b0;
      #1;
      chk("rdata", rdata, e);
   endtask
   // covers output latency and two sync flops
   task automatic settle();
      repeat (4) @(posedge clk_i);
      #1;
   endtask
   // verdict
   task automatic results();
      $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset();
      #1;
      chk("pin_oe", poe, '0);
      chk("pin_pu", ppu, '0);
      chk("pin_out", pout, '0);
      for (int p = 0; p < 5; p++) begin
         rdc(8'(3 * p), 8'h00);
         rdc(8'(3 * p + 1), 8'h00);
      end
   endtask
   task automatic t_regs();
      wr8(8'h00, 8'hA5);
      wr8(8'h01, 8'h3C);
      wr8(8'h0C, 8'hFF);
      wr8(8'h20, 8'h5A);
      rdc(8'h00, 8'hA5);
      rdc(8'h01, 8'h3C);
      rdc(8'h0C, 8'h07);
      rdc(8'h20, 8'h00);
      chk("port_a", {poe[0], ppu[0], pout[0] & 8'h3C}, 24'h3C8124);
      rdc(8'h02, 8'hA5);
      // write while frozen must not land
      @(posedge clk_i);
      ce <= 1'b0;
      wr8(8'h00, 8'h00);
      ce <= 1'b1;
      rdc(8'h00, 8'hA5);
      wr8(8'h0C, 8'h00);
      @(posedge clk_i);
      ext[1] <= 8'h6C;
      settle();
      rdc(8'h05, 8'h6C);
   endtask
   task automatic t_serial0();
      wr8(8'h09, 8'hC3);
      wr8(8'h0A, 8'h01);
      pi.serial0_tx_on   <= 1'b1;
      pi.serial0_tx_line <= 1'b1;
      pi.serial0_rx_on   <= 1'b1;
      settle();
      chk("d1", {poe[3][1], ppu[3][1], pout[3][1]}, 3'b101);
      chk("d0", {poe[3][0], ppu[3][0], po.serial0_rx_line}, 3'b011);
      wr8(8'h0F, 8'h01);
      settle();
      chk("d0_pu", ppu[3][0], 1'b0);
   endtask
   task automatic t_xmem();
      pi.mem_read_strobe <= 1'b1;
      pi.mem_addr_latch  <= 1'b1;
      wr8(8'h0F, 8'h02);
      settle();
      chk("strb_oe", {poe[3][7:6], poe[4][1], xmem}, 4'hF);
      chk("strb_pu", {ppu[3][7:6], ppu[4][1]}, 3'b000);
      chk("strb_out", {pout[3][7:6], pout[4][1]}, 3'b101);
      wr8(8'h0F, 8'h00);
      settle();
      chk("d7_pu", ppu[3][7], 1'b1);
   endtask
   task automatic t_d4_d2();
      pi.timer3_compare_a_on  <= 1'b1;
      pi.timer3_compare_a_out <= 1'b1;
      settle();
      chk("d4_cmp", pout[3][4], 1'b1);
      pi.serial0_clk_out_on <= 1'b1;
      settle();
      chk("d4_clk", pout[3][4], 1'b0);
      wr8(8'h0A, 8'h05);
      pi.serial1_sync_mode <= 1'b1;
      pi.serial1_ext_clock <= 1'b1;
      pi.ext_irq0_on       <= 1'b1;
      settle();
      chk("d2", {poe[3][2], pout[3][2]}, 2'b11);
      chk("d2_in", {po.ext_irq0_in, po.serial1_ext_clock_in}, 2'b11);
      pi.serial1_sync_mode <= 1'b0;
      settle();
      chk("d2_io", {pout[3][2], po.serial1_ext_clock_in}, 2'b00);
   endtask
   task automatic t_e_osc();
      wr8(8'h0D, 8'h04);
      pi.timer1_compare_b_on  <= 1'b1;
      pi.timer1_compare_b_out <= 1'b1;
      pi.ext_irq2_on          <= 1'b1;
      pi.timer1_compare_a_on  <= 1'b1;
      pi.timer1_compare_a_out <= 1'b1;
      pi.ext_irq1_on          <= 1'b1;
      ext <= {8'h01, 8'h18, 8'h00, 8'h6C, 8'h00};
      settle();
      chk("e2", {poe[4][2], pout[4][2]}, 2'b11);
      chk("e0", {po.timer1_capture_in, po.ext_irq2_in}, 2'b11);
      chk("d4_d3", {po.serial0_ext_clock_in, po.ext_irq1_in, pout[3][5]},
          3'b111);
      wr8(8'h0A, 8'h35);
      wr8(8'h0F, 8'h04);
      ext[3] <= 8'h30;
      settle();
      chk("osc", {poe[3][5:4], ppu[3][5:4], osc}, 5'h01);
      chk("d4_in_off", po.serial0_ext_clock_in, 1'b0);
      rdc(8'h0B, 8'hC3);
   endtask

   // main sequence
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      t_reset();
      t_regs();
      t_serial0();
      t_xmem();
      t_d4_d2();
      t_e_osc();
      results();
   end
   // watchdog
   initial begin
      #40000;
      error_cnt++;
      results();
   end
endmodule
`default_nettype wire

// ==== common/iopo_cfg.svh ====
// offsets, field positions and reset values of the pin override block
`ifndef IOPO_CFG_SVH
`define IOPO_CFG_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define IOPO_NPORTS        5
`define IOPO_PORT_W        8
`define IOPO_ADDR_W        8
`define IOPO_PORT_A        0
`define IOPO_PORT_D        3
`define IOPO_PORT_E        4
`define IOPO_PORT_E_MASK   8'h07

// ****************************************************************
// register offsets: three per port, then the control word
// ****************************************************************
`define IOPO_REGS_PER_PORT 3
`define IOPO_OFF_LATCH     0
`define IOPO_OFF_DIR       1
`define IOPO_OFF_PIN       2
`define IOPO_OFF_CTRL      8'h0F

// ****************************************************************
// control word fields and reset values
// ****************************************************************
`define IOPO_CTRL_W        3
`define IOPO_CTRL_PU_OFF   0
`define IOPO_CTRL_XMEM     1
`define IOPO_CTRL_T2_ASYNC 2
`define IOPO_CTRL_RST      3'h0
`define IOPO_LATCH_RST     8'h00
`define IOPO_DIR_RST       8'h00

`endif

// ==== common/iopo_pkg.sv ====
// types shared by the pin override block
package iopo_pkg;
`include "iopo_cfg.svh"

   // one byte per port, port a at index 0
   typedef logic [`IOPO_NPORTS-1:0][`IOPO_PORT_W-1:0] iopo_bank_t;

   // override enable/value pairs of one pin
   typedef struct packed {
      logic pullup_override_en;
      logic pullup_override_val;
      logic dir_override_en;
      logic dir_override_val;
      logic outval_override_en;
      logic outval_override_val;
      logic inbuf_override_en;
      logic inbuf_override_val;
   } iopo_ovr_s;

   typedef iopo_ovr_s [`IOPO_NPORTS-1:0][`IOPO_PORT_W-1:0] iopo_ovr_bank_t;

   // resolved drive of one pin
   typedef struct packed {
      logic pu;
      logic oe;
      logic out;
      logic die;
   } iopo_drv_s;

   // function signals from on-chip peripherals
   typedef struct packed {
      logic serial0_tx_on;
      logic serial0_tx_line;
      logic serial0_rx_on;
      logic serial0_clk_out_on;
      logic serial0_ext_clock;
      logic serial1_sync_mode;
      logic serial1_ext_clock;
      logic timer1_compare_a_on;
      logic timer1_compare_a_out;
      logic timer3_compare_a_on;
      logic timer3_compare_a_out;
      logic timer1_compare_b_on;
      logic timer1_compare_b_out;
      logic mem_read_strobe;
      logic mem_write_strobe;
      logic mem_addr_latch;
      logic ext_irq0_on;
      logic ext_irq1_on;
      logic ext_irq2_on;
   } iopo_periph_in_s;

   // pin levels handed to peripherals
   typedef struct packed {
      logic serial0_rx_line;
      logic serial0_ext_clock_in;
      logic serial1_ext_clock_in;
      logic ext_irq0_in;
      logic ext_irq1_in;
      logic ext_irq2_in;
      logic timer1_capture_in;
   } iopo_periph_out_s;

   // whole state of the top module
   typedef struct packed {
      iopo_bank_t                 latch;
      iopo_bank_t                 dir;
      logic [`IOPO_CTRL_W-1:0]    ctrl;
      logic [`IOPO_PORT_W-1:0]    rdata;
      iopo_bank_t                 pout;
      iopo_bank_t                 poe;
      iopo_bank_t                 ppu;
      iopo_periph_out_s           periph;
      logic                       ext_mem;
      logic                       osc;
   } iopo_state_s;

endpackage

// ==== logic/iopo_pin_cell.sv ====
// resolution of register control and overrides for one pin
`timescale 1ns/1ps
`default_nettype none

module iopo_pin_cell
   import iopo_pkg::*;
(
   // register side
   input  wire logic      latch_i,
   input  wire logic      dir_i,
   input  wire logic      pu_off_i,
   // pin side
   input  wire logic      lvl_i,
   input  wire iopo_ovr_s ovr_i,
   // results
   output iopo_drv_s      drv_o,
   output logic          di_o
);

   // override value replaces register-derived control when enabled
   always_comb begin
      drv_o.pu  = ovr_i.pullup_override_en ? ovr_i.pullup_override_val
                : (latch_i & ~dir_i & ~pu_off_i);
      drv_o.oe  = ovr_i.dir_override_en ? ovr_i.dir_override_val
                : dir_i;
      drv_o.out = ovr_i.outval_override_en ? ovr_i.outval_override_val
                : latch_i;
      drv_o.die = ovr_i.inbuf_override_en ? ovr_i.inbuf_override_val
                : 1'b1;
      di_o      = lvl_i & drv_o.die;
   end

endmodule

`default_nettype wire

// ==== logic/iopo_sync.sv ====
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none

module iopo_sync #(
   parameter int W = 8
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic         ce_i,
   // levels
   input  wire logic [W-1:0] d_i,
   output logic [W-1:0]      q_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } iopo_sync_state_s;

   iopo_sync_state_s s_q;
   iopo_sync_state_s s_d;

   // first stage feeds only the second
   always_comb begin
      s_d        = s_q;
      s_d.meta   = d_i;
      s_d.stable = s_q.meta;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   assign q_o = s_q.stable;

endmodule

`default_nettype wire

// ==== logic/iopo_top.sv ====
// port registers and alternate function overrides of five i/o ports
// ****************************************************************
// Notes on behaviour
// - second serial clock pin drives out when its direction bit is one
// - second serial clock pin works only in synchronous serial mode
// - transmitter on: transmit pin output, drives data, pull-up off
// - receiver on: receive pin forced input, level passed to receiver
// - receive pin pull-up follows latch bit unless pull-ups globally off
// - external memory on: strobe pins output, no pull-up, input unused
// - shared clock/compare pin: serial clock wins, else compare output
// - enabled irq forces input buffer on, rest stays register driven except the d2 serial clock output
// - irq0 pin level feeds irq logic and second serial clock input
// - external memory on: latch-enable pin output, pull-up off
// - compare-b drives its pin when enabled; software sets direction
// - capture/irq pin level always feeds timer1 capture
// - irq2 enabled: capture/irq pin input buffer on, level to irq
// - data registers: eight read/write bits (three on port e), reset zero
// - direction registers reset zero, so all pins start as inputs
// - input registers read sampled pin levels, synchroniser flops reset to zero
// - async timer2 clocking: oscillator pins cut off from port logic
// ****************************************************************
`timescale 1ns/1ps
`default_nettype none
`include "iopo_cfg.svh"

module iopo_top
   import iopo_pkg::*;
(
   // clock, reset, enable
   input  wire logic                    clk_i,
   input  wire logic                    rst_n_i,
   input  wire logic                    ce_i,
   // register port
   input  wire logic [`IOPO_ADDR_W-1:0] reg_addr_i,
   input  wire logic [`IOPO_PORT_W-1:0] reg_wdata_i,
   input  wire logic                    reg_wr_i,
   input  wire logic                    reg_rd_i,
   output logic [`IOPO_PORT_W-1:0]      reg_rdata_o,
   // pins
   input  wire iopo_bank_t              pin_lvl_i,
   output iopo_bank_t                   pin_out_o,
   output iopo_bank_t                   pin_oe_o,
   output iopo_bank_t                   pin_pu_o,
   // peripherals
   input  wire iopo_periph_in_s         periph_i,
   output iopo_periph_out_s             periph_o,
   // system control
   output logic                         ext_memory_on_o,
   output logic                         osc_pins_on_o
);

   localparam int NP = `IOPO_NPORTS;
   localparam int PW = `IOPO_PORT_W;
   localparam int PD = `IOPO_PORT_D;
   localparam int PE = `IOPO_PORT_E;

   iopo_state_s    s_q;
   iopo_state_s    s_d;
   iopo_bank_t     pin_sync;
   iopo_ovr_bank_t ovr;
   iopo_drv_s      drv [NP][PW];
   iopo_bank_t     di;
   logic           global_pullup_off;
   logic           ext_memory_on;
   logic           timer2_async_select;
   logic           sclk1_drive;

   // ****************************************************************
   // helpers
   // ****************************************************************

   // implemented bits of a port
   function automatic logic [PW-1:0] port_mask(input int p);
      return (p == PE) ? `IOPO_PORT_E_MASK : {PW{1'b1}};
   endfunction

   // address of register kind k of port p
   function automatic logic reg_hit(input logic [`IOPO_ADDR_W-1:0] a,
                                    input int p, input int k);
      return a == `IOPO_ADDR_W'((p * `IOPO_REGS_PER_PORT) + k);
   endfunction

   // ****************************************************************
   // pin synchroniser and per-pin resolution
   // ****************************************************************

   iopo_sync #(
      .W       (NP * PW)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .d_i     (pin_lvl_i),
      .q_o     (pin_sync)
   );

   assign global_pullup_off   = s_q.ctrl[`IOPO_CTRL_PU_OFF];
   assign ext_memory_on       = s_q.ctrl[`IOPO_CTRL_XMEM];
   assign timer2_async_select = s_q.ctrl[`IOPO_CTRL_T2_ASYNC];
   // clock leaves only in sync mode with direction bit set
   assign sclk1_drive = periph_i.serial1_sync_mode
                      & s_q.dir[PD][2];

   for (genvar p = 0; p < NP; p++) begin : g_port
      for (genvar b = 0; b < PW; b++) begin : g_bit
         iopo_pin_cell u_cell (
            .latch_i (s_q.latch[p][b]),
            .dir_i   (s_q.dir[p][b]),
            .pu_off_i(global_pullup_off),
            .lvl_i   (pin_sync[p][b]),
            .ovr_i   (ovr[p][b]),
            .drv_o   (drv[p][b]),
            .di_o    (di[p][b])
         );
      end
   end

   // ****************************************************************
   // override table for ports d and e
   // ****************************************************************

   // all other pins stay under plain register control
   always_comb begin
      ovr = '0;
      // read and write strobes
      for (int b = 6; b < 8; b++) begin
         ovr[PD][b].pullup_override_en = ext_memory_on;
         ovr[PD][b].dir_override_en    = ext_memory_on;
         ovr[PD][b].dir_override_val   = 1'b1;
         ovr[PD][b].outval_override_en = ext_memory_on;
      end
      ovr[PD][7].outval_override_val = periph_i.mem_read_strobe;
      ovr[PD][6].outval_override_val = periph_i.mem_write_strobe;
      // oscillator pins
      for (int b = 4; b < 6; b++) begin
         ovr[PD][b].pullup_override_en = timer2_async_select;
         ovr[PD][b].dir_override_en    = timer2_async_select;
         ovr[PD][b].inbuf_override_en  = timer2_async_select;
      end
      ovr[PD][5].outval_override_en  = periph_i.timer1_compare_a_on;
      ovr[PD][5].outval_override_val = periph_i.timer1_compare_a_out;
      // serial clock has priority over compare output
      ovr[PD][4].outval_override_en  = periph_i.serial0_clk_out_on
                                     | periph_i.timer3_compare_a_on;
      ovr[PD][4].outval_override_val = periph_i.serial0_clk_out_on
                                     ? periph_i.serial0_ext_clock
                                     : periph_i.timer3_compare_a_out;
      // interrupt pins keep register control except the buffer and the d2 serial clock output
      ovr[PD][3].inbuf_override_en  = periph_i.ext_irq1_on;
      ovr[PD][3].inbuf_override_val = 1'b1;
      ovr[PD][2].inbuf_override_en  = periph_i.ext_irq0_on;
      ovr[PD][2].inbuf_override_val = 1'b1;
      ovr[PD][2].outval_override_en  = sclk1_drive;
      ovr[PD][2].outval_override_val = periph_i.serial1_ext_clock;
      // transmit pin
      ovr[PD][1].pullup_override_en  = periph_i.serial0_tx_on;
      ovr[PD][1].dir_override_en     = periph_i.serial0_tx_on;
      ovr[PD][1].dir_override_val    = 1'b1;
      ovr[PD][1].outval_override_en  = periph_i.serial0_tx_on;
      ovr[PD][1].outval_override_val = periph_i.serial0_tx_line;
      // receive pin keeps a latch-driven pull-up
      ovr[PD][0].pullup_override_en  = periph_i.serial0_rx_on;
      ovr[PD][0].pullup_override_val = s_q.latch[PD][0]
                                     & ~global_pullup_off;
      ovr[PD][0].dir_override_en     = periph_i.serial0_rx_on;
      // port e: compare-b, latch enable, capture/irq2
      ovr[PE][2].outval_override_en  = periph_i.timer1_compare_b_on;
      ovr[PE][2].outval_override_val = periph_i.timer1_compare_b_out;
      ovr[PE][1].pullup_override_en  = ext_memory_on;
      ovr[PE][1].dir_override_en     = ext_memory_on;
      ovr[PE][1].dir_override_val    = 1'b1;
      ovr[PE][1].outval_override_en  = ext_memory_on;
      ovr[PE][1].outval_override_val = periph_i.mem_addr_latch;
      ovr[PE][0].inbuf_override_en   = periph_i.ext_irq2_on;
      ovr[PE][0].inbuf_override_val  = 1'b1;
   end

   // ****************************************************************
   // next state: registers, read data, pin drive, peripheral levels
   // ****************************************************************

   always_comb begin
      s_d = s_q;
      // register writes, unimplemented bits held at zero
      for (int p = 0; p < NP; p++) begin
         if (reg_wr_i && reg_hit(reg_addr_i, p, `IOPO_OFF_LATCH)) begin
            s_d.latch[p] = reg_wdata_i & port_mask(p);
         end
         if (reg_wr_i && reg_hit(reg_addr_i, p, `IOPO_OFF_DIR)) begin
            s_d.dir[p] = reg_wdata_i & port_mask(p);
         end
      end
      if (reg_wr_i && reg_addr_i == `IOPO_OFF_CTRL) begin
         s_d.ctrl = reg_wdata_i[`IOPO_CTRL_W-1:0];
      end
      // read data for one cycle, zero when unmapped or idle
      s_d.rdata = '0;
      if (reg_rd_i) begin
         for (int p = 0; p < NP; p++) begin
            if (reg_hit(reg_addr_i, p, `IOPO_OFF_LATCH)) begin
               s_d.rdata = s_q.latch[p];
            end
            if (reg_hit(reg_addr_i, p, `IOPO_OFF_DIR)) begin
               s_d.rdata = s_q.dir[p];
            end
            if (reg_hit(reg_addr_i, p, `IOPO_OFF_PIN)) begin
               s_d.rdata = di[p] & port_mask(p);
            end
         end
         if (reg_addr_i == `IOPO_OFF_CTRL) begin
            s_d.rdata = PW'(s_q.ctrl);
         end
      end
      // pin drive, resolved per pin
      for (int p = 0; p < NP; p++) begin
         for (int b = 0; b < PW; b++) begin
            s_d.pout[p][b] = drv[p][b].out;
            s_d.poe[p][b]  = drv[p][b].oe;
            s_d.ppu[p][b]  = drv[p][b].pu;
         end
         // unimplemented port e bits never drive
         s_d.pout[p] = s_d.pout[p] & port_mask(p);
         s_d.poe[p]  = s_d.poe[p] & port_mask(p);
         s_d.ppu[p]  = s_d.ppu[p] & port_mask(p);
      end
      // levels toward peripherals
      s_d.periph.serial0_rx_line      = di[PD][0];
      s_d.periph.serial0_ext_clock_in = di[PD][4];
      s_d.periph.ext_irq0_in          = di[PD][2];
      s_d.periph.serial1_ext_clock_in = di[PD][2]
                                      & periph_i.serial1_sync_mode;
      s_d.periph.ext_irq1_in          = di[PD][3];
      s_d.periph.ext_irq2_in          = di[PE][0];
      s_d.periph.timer1_capture_in    = pin_sync[PE][0];
      s_d.ext_mem = ext_memory_on;
      s_d.osc     = timer2_async_select;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         s_q       <= '0;
         s_q.latch <= {NP{`IOPO_LATCH_RST}};
         s_q.dir   <= {NP{`IOPO_DIR_RST}};
         s_q.ctrl  <= `IOPO_CTRL_RST;
      end else if (ce_i) begin
         s_q <= s_d;
      end
   end

   // outputs straight from the state register
   assign reg_rdata_o     = s_q.rdata;
   assign pin_out_o       = s_q.pout;
   assign pin_oe_o        = s_q.poe;
   assign pin_pu_o        = s_q.ppu;
   assign periph_o        = s_q.periph;
   assign ext_memory_on_o = s_q.ext_mem;
   assign osc_pins_on_o   = s_q.osc;

   // ****************************************************************
   // assertions
   // ****************************************************************

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_sclk1_dir_out: assert property (
      (ce_i && periph_i.serial1_sync_mode && s_q.dir[PD][2]) |=>
      pin_oe_o[PD][2] && pin_out_o[PD][2] == $past(periph_i.serial1_ext_clock))
      else $error("serial1 clock not driven out");
   a_sclk1_async_io: assert property (
      (ce_i && !periph_i.serial1_sync_mode) |=>
      pin_out_o[PD][2] == $past(s_q.latch[PD][2])
      && !periph_o.serial1_ext_clock_in)
      else $error("serial1 clock pin used outside sync mode");
   a_tx_forced: assert property (
      (ce_i && periph_i.serial0_tx_on) |=> pin_oe_o[PD][1]
      && !pin_pu_o[PD][1] && pin_out_o[PD][1] == $past(periph_i.serial0_tx_line))
      else $error("transmit pin not forced out");
   a_rx_forced: assert property (
      (ce_i && periph_i.serial0_rx_on) |=> !pin_oe_o[PD][0]
      && periph_o.serial0_rx_line == $past(pin_sync[PD][0]))
      else $error("receive pin not forced in");
   a_rx_pullup: assert property (
      (ce_i && periph_i.serial0_rx_on) |=>
      pin_pu_o[PD][0] == $past(s_q.latch[PD][0] && !global_pullup_off))
      else $error("receive pull-up wrong");
   a_mem_strobes: assert property (
      (ce_i && ext_memory_on) |=> pin_oe_o[PD][7] && pin_oe_o[PD][6]
      && !pin_pu_o[PD][7] && !pin_pu_o[PD][6]
      && pin_out_o[PD][7] == $past(periph_i.mem_read_strobe)
      && pin_out_o[PD][6] == $past(periph_i.mem_write_strobe))
      else $error("memory strobes not driven");
   a_clk_cmp_prio: assert property (
      (ce_i && !periph_i.serial0_clk_out_on && periph_i.timer3_compare_a_on)
      |=> pin_out_o[PD][4] == $past(periph_i.timer3_compare_a_out))
      else $error("compare output lost on shared pin");
   a_irq1_inbuf: assert property (
      (ce_i && periph_i.ext_irq1_on) |=>
      periph_o.ext_irq1_in == $past(pin_sync[PD][3]))
      else $error("irq1 level not passed");
   a_irq0_route: assert property (
      (ce_i && periph_i.ext_irq0_on && periph_i.serial1_sync_mode) |=>
      periph_o.ext_irq0_in == periph_o.serial1_ext_clock_in)
      else $error("irq0 pin routes disagree");
   a_ale_drive: assert property (
      (ce_i && ext_memory_on) |=> pin_oe_o[PE][1] && !pin_pu_o[PE][1]
      && pin_out_o[PE][1] == $past(periph_i.mem_addr_latch))
      else $error("address latch enable not driven");
   a_cmpb_out: assert property (
      (ce_i && periph_i.timer1_compare_b_on) |=>
      pin_out_o[PE][2] == $past(periph_i.timer1_compare_b_out)
      && pin_oe_o[PE][2] == $past(s_q.dir[PE][2]))
      else $error("compare-b pin wrong");
   a_capture_feed: assert property (
      ce_i |=> periph_o.timer1_capture_in == $past(pin_sync[PE][0]))
      else $error("capture level not passed");
   a_reset_zero: assert property (
      $past(!rst_n_i) |-> s_q.latch == '0 && s_q.dir == '0)
      else $error("port registers not zero after reset");
   a_pin_read: assert property (
      (ce_i && reg_rd_i && reg_hit(reg_addr_i, `IOPO_PORT_A, `IOPO_OFF_PIN))
      |=> reg_rdata_o == $past(di[`IOPO_PORT_A]))
      else $error("input register read wrong");
   a_osc_isolate: assert property (
      (ce_i && timer2_async_select) |=> osc_pins_on_o && !pin_oe_o[PD][5]
      && !pin_oe_o[PD][4] && !pin_pu_o[PD][5] && !pin_pu_o[PD][4])
      else $error("oscillator pins still on port");

   c_tx_active: cover property (ce_i && periph_i.serial0_tx_on ##1 ce_i);
   c_ext_mem: cover property (ce_i && ext_memory_on && reg_wr_i);
   c_irq2_seen: cover property (periph_i.ext_irq2_on && periph_o.ext_irq2_in);

endmodule

`default_nettype wire
